/* hdl/rdo_pkg.sv */
package rdo_pkg;
  // Request word layout
  localparam int RESERVED_TOP_BIT  = 31;
  localparam int POS_MSB           = 30;
  localparam int POS_LSB           = 28;
  localparam int GIVEBACK_BIT      = 27;
  localparam int MISMATCH_BIT      = 26;
  localparam int USB_COMM_BIT      = 25;
  localparam int NO_SUSPEND_BIT    = 24;
  localparam int RSVD_MID_MSB      = 23;
  localparam int RSVD_MID_LSB      = 20;
  localparam int OPER_MSB          = 19;
  localparam int OPER_LSB          = 10;
  localparam int LIMIT_MSB         = 9;
  localparam int LIMIT_LSB         = 0;
  localparam int FIELD_W           = 10;
  localparam int POS_W             = 3;
  localparam int NUM_ENTRIES       = 7;
  localparam int CURRENT_STEP_MA   = 10;
  localparam int POWER_STEP_MW     = 250;
  // Offered capability entry layout
  localparam int CAP_TYPE_MSB      = 31;
  localparam int CAP_TYPE_LSB      = 30;
  localparam logic [1:0] SUPPLY_FIXED    = 2'h0;
  localparam logic [1:0] SUPPLY_BATTERY  = 2'h1;
  localparam logic [1:0] SUPPLY_VARIABLE = 2'h2;
  localparam logic [2:0] POS_RESERVED    = 3'h0;
  localparam logic [2:0] POS_FIRST       = 3'h1;
  // Register map
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_OPER   = 4'h1;
  localparam logic [3:0] ADDR_MAXV   = 4'h2;
  localparam logic [3:0] ADDR_MINV   = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RDO    = 4'h5;
  localparam logic [3:0] ADDR_CAPS   = 4'h8;
  localparam logic [31:0] CTRL_RESET = 32'h0;
  localparam int CTRL_POS_LSB    = 0;
  localparam int CTRL_GB_BIT     = 4;
  localparam int CTRL_USB_BIT    = 5;
  localparam int CTRL_NOSUSP_BIT = 6;
  localparam int CTRL_BUILD_BIT  = 8;

  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_EMIT} build_state_t;

  function automatic logic is_battery(input logic [31:0] cap);
    return cap[CAP_TYPE_MSB:CAP_TYPE_LSB] == SUPPLY_BATTERY;
  endfunction
  function automatic logic [FIELD_W-1:0] cap_limit(input logic [31:0] cap);
    return cap[FIELD_W-1:0];
  endfunction
endpackage

/* hdl/rdo_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rdo_if;
  import rdo_pkg::*;
  logic [POS_W-1:0]   pos;
  logic [31:0]        cap;
  logic               pos_ok;
  logic               is_batt;
  logic [FIELD_W-1:0] limit;
  modport table_side (input pos, output cap, output pos_ok, output is_batt, output limit);
  modport user_side  (output pos, input cap, input pos_ok, input is_batt, input limit);
endinterface
`default_nettype wire

/* hdl/rdo_cap_table.sv */
`timescale 1ns/1ps
`default_nettype none
module rdo_cap_table
  import rdo_pkg::*;
(
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset,
  input  wire logic                 i_caps_clear,
  input  wire logic                 i_cap_we,
  input  wire logic [POS_W-1:0]     i_cap_idx,
  input  wire logic [31:0]          i_cap_wdata,
  output logic      [POS_W:0]       o_count,
  rdo_if.table_side                 lk
);
  typedef struct packed {
    logic [NUM_ENTRIES-1:0][31:0] caps;
    logic [POS_W:0]               count;
  } tab_t;
  tab_t s_q;
  tab_t s_d;

  always_comb
  begin
    s_d = s_q;
    // Fresh offer zeroes the count; old entries stay, but positions above the new count never validate
    if (i_caps_clear)
    begin
      s_d.count = '0;
    end
    if (i_cap_we && i_cap_idx != POS_RESERVED)
    begin
      s_d.caps[i_cap_idx - POS_FIRST] = i_cap_wdata;
      if ({1'b0, i_cap_idx} > s_d.count)
      begin
        s_d.count = {1'b0, i_cap_idx};
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_count    = s_q.count;
  assign lk.pos_ok  = (lk.pos != POS_RESERVED) && ({1'b0, lk.pos} <= s_q.count);
  assign lk.cap     = (lk.pos == POS_RESERVED) ? 32'h0 : s_q.caps[lk.pos - POS_FIRST];
  assign lk.is_batt = is_battery(lk.cap);
  assign lk.limit   = cap_limit(lk.cap);
endmodule
`default_nettype wire

/* hdl/rdo_checker_core.sv */
`timescale 1ns/1ps
`default_nettype none
module rdo_checker_core
  import rdo_pkg::*;
(
  input  wire logic                 i_pos_ok,
  input  wire logic                 i_giveback,
  input  wire logic [FIELD_W-1:0]   i_offer,
  input  wire logic [FIELD_W-1:0]   i_oper,
  input  wire logic [FIELD_W-1:0]   i_maxv,
  input  wire logic [FIELD_W-1:0]   i_minv,
  output logic                      o_mismatch,
  output logic [FIELD_W-1:0]        o_oper,
  output logic [FIELD_W-1:0]        o_low,
  output logic                      o_ok
);
  logic need_more;
  always_comb
  begin
    // Need above the offer: clamp operating value, flag mismatch
    need_more  = (i_oper > i_offer) || (!i_giveback && i_maxv > i_offer);
    o_mismatch = need_more;
    o_oper     = (i_oper > i_offer) ? i_offer : i_oper;
    if (i_giveback)
    begin
      o_low = (i_minv > o_oper) ? o_oper : i_minv;
    end
    else
    begin
      o_low = (i_maxv < o_oper) ? o_oper : i_maxv;
    end
    o_ok = i_pos_ok;
  end
endmodule
`default_nettype wire

/* hdl/power_request_object_builder.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE_01 - Position 1 picks first offered entry, 2 the second, upward.
// RULE_02 - GiveBack set only when software commits to drop to minimum.
// RULE_03 - Unmet need still yields valid request with mismatch bit set.
// RULE_04 - Position must reference latest offer list, within its length.
// RULE_05 - Operating value never exceeds the selected entry's offered maximum.
// RULE_06 - Mismatch without GiveBack lets maximum field exceed the offer.
// RULE_07 - No mismatch, no GiveBack: maximum field within the offer.
// RULE_08 - USB communications flag mirrors data-line capability input.
// RULE_09 - No-suspend flag optional, driven from software control.
// RULE_10 - Source decides on re-offer after seeing no-suspend.
// RULE_11 - Operating current carried now; rebuild on every need change.
// RULE_12 - Without GiveBack, operating value at most the maximum field.
// RULE_13 - Source reserve equals maximum minus operating without GiveBack.
// RULE_14 - Source answers Wait while reserve is lent out.
// RULE_15 - With GiveBack, operating value at least the minimum field.
// RULE_16 - Battery requests carry operating power with maximum power.
// RULE_17 - Battery maximum power bounded by offer unless mismatch.
// RULE_18 - Battery GiveBack carries minimum operating power.
// RULE_19 - Position bits 30..28, zero reserved; bits 31, 23..20 zero.
// RULE_20 - Flags at bits 27, 26, 25, 24.
// RULE_21 - Fixed/variable fields bits 19..10 and 9..0 in 10 mA.
// RULE_22 - Battery fields same positions in 250 mW steps.
// RULE_23 - Entry supply type picks power or current; GiveBack picks low meaning.
module power_request_object_builder
  import rdo_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_usb_data_capable,
  input  wire logic        i_caps_received,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic      [31:0] o_rdo,
  output logic             o_rdo_valid,
  output logic             o_rdo_error
);
  typedef struct packed {
    build_state_t        st;
    logic [31:0]         ctrl;
    logic [FIELD_W-1:0]  oper;
    logic [FIELD_W-1:0]  maxv;
    logic [FIELD_W-1:0]  minv;
    logic [31:0]         rdo;
    logic                valid;
    logic                error;
    logic                pending;
    logic [31:0]         rdata;
  } state_t;
  state_t s_q;
  state_t s_d;

  rdo_if lk ();

  logic [POS_W:0]      cap_count;
  logic                chk_mismatch;
  logic [FIELD_W-1:0]  chk_oper;
  logic [FIELD_W-1:0]  chk_low;
  logic                chk_ok;
  logic                cap_we;
  logic                gb;
  logic                build_req;

  assign gb     = s_q.ctrl[CTRL_GB_BIT];
  assign build_req = i_wr && ((i_addr == ADDR_CTRL && i_wdata[CTRL_BUILD_BIT]) ||
                              i_addr == ADDR_OPER || i_addr == ADDR_MAXV || i_addr == ADDR_MINV);
  assign cap_we = i_wr && i_addr >= ADDR_CAPS && i_addr < ADDR_CAPS + 4'(NUM_ENTRIES);
  assign lk.pos = s_q.ctrl[CTRL_POS_LSB +: POS_W]; // [RULE_01]

  rdo_cap_table u_table (
    .i_mclk       (i_mclk),
    .i_reset      (i_reset),
    .i_caps_clear (i_caps_received),
    .i_cap_we     (cap_we),
    .i_cap_idx    (3'(i_addr - ADDR_CAPS + 4'h1)),
    .i_cap_wdata  (i_wdata),
    .o_count      (cap_count),
    .lk           (lk)
  );

  rdo_checker_core u_check (
    .i_pos_ok   (lk.pos_ok),
    .i_giveback (gb),
    .i_offer    (lk.limit),
    .i_oper     (s_q.oper),
    .i_maxv     (s_q.maxv),
    .i_minv     (s_q.minv),
    .o_mismatch (chk_mismatch),
    .o_oper     (chk_oper),
    .o_low      (chk_low),
    .o_ok       (chk_ok)
  );

  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 32'h0;
    // A new offer voids the standing request until rebuilt
    if (i_caps_received)
    begin
      s_d.valid = 1'b0; // [RULE_04]
    end
    if (i_wr)
    begin
      case (i_addr)
        ADDR_CTRL:
        begin
          s_d.ctrl    = i_wdata & 32'h0000_0077;
          s_d.pending = s_d.pending | i_wdata[CTRL_BUILD_BIT];
        end
        ADDR_OPER:
        begin
          s_d.oper    = i_wdata[FIELD_W-1:0];
          s_d.pending = 1'b1; // [RULE_11]
        end
        ADDR_MAXV:
        begin
          s_d.maxv    = i_wdata[FIELD_W-1:0];
          s_d.pending = 1'b1;
        end
        ADDR_MINV:
        begin
          s_d.minv    = i_wdata[FIELD_W-1:0];
          s_d.pending = 1'b1;
        end
        default:
        begin
        end
      endcase
    end
    if (i_rd)
    begin
      case (i_addr)
        ADDR_CTRL:   s_d.rdata = s_q.ctrl;
        ADDR_OPER:   s_d.rdata = {22'h0, s_q.oper};
        ADDR_MAXV:   s_d.rdata = {22'h0, s_q.maxv};
        ADDR_MINV:   s_d.rdata = {22'h0, s_q.minv};
        ADDR_STATUS: s_d.rdata = {24'h0, cap_count, 1'b0, s_q.pending, s_q.error, s_q.valid};
        ADDR_RDO:    s_d.rdata = s_q.rdo;
        default:     s_d.rdata = 32'h0;
      endcase
    end
    case (s_q.st)
      ST_IDLE:
      begin
        if (s_q.pending)
        begin
          s_d.st      = ST_CHECK;
          // A strobe landing now must not be lost to the clear
          s_d.pending = build_req; // [RULE_11]
        end
      end
      ST_CHECK:
      begin
        if (!chk_ok)
        begin
          // Bad or stale position: never emit a request pointing at it
          s_d.error = 1'b1; // [RULE_04]
          s_d.valid = 1'b0;
          s_d.st    = ST_IDLE;
        end
        else
        begin
          s_d.st = ST_EMIT;
        end
      end
      ST_EMIT:
      begin
        s_d.rdo = 32'h0; // [RULE_19]
        s_d.rdo[POS_MSB:POS_LSB]    = lk.pos; // [RULE_01] [RULE_19]
        s_d.rdo[GIVEBACK_BIT]       = gb; // [RULE_02] [RULE_20]
        s_d.rdo[MISMATCH_BIT]       = chk_mismatch; // [RULE_03] [RULE_06] [RULE_17]
        s_d.rdo[USB_COMM_BIT]       = i_usb_data_capable; // [RULE_08]
        s_d.rdo[NO_SUSPEND_BIT]     = s_q.ctrl[CTRL_NOSUSP_BIT]; // [RULE_09]
        // Same slots for current and power; unit follows entry type
        s_d.rdo[OPER_MSB:OPER_LSB]  = chk_oper; // [RULE_05] [RULE_16] [RULE_21] [RULE_22] [RULE_23]
        // Low field: max without GiveBack, min with it; clamped around oper
        s_d.rdo[LIMIT_MSB:LIMIT_LSB] = chk_low; // [RULE_07] [RULE_12] [RULE_15] [RULE_18] [RULE_23]
        // Offer may have been wiped while checking; never validate a stale position
        s_d.valid = chk_ok && !i_caps_received; // [RULE_04]
        s_d.error = 1'b0;
        s_d.st    = ST_IDLE;
      end
      default:
      begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      s_q <= '{st: ST_IDLE, ctrl: CTRL_RESET, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_rdata     = s_q.rdata;
  assign o_rdo       = s_q.rdo;
  assign o_rdo_valid = s_q.valid;
  assign o_rdo_error = s_q.error;
endmodule
`default_nettype wire

/* verif/power_request_object_builder_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module power_request_object_builder_chk
  import rdo_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_reset,
  input wire logic        i_usb_data_capable,
  input wire logic        i_caps_received,
  input wire logic [3:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [31:0] o_rdo,
  input wire logic        o_rdo_valid,
  input wire logic        o_rdo_error
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  wire logic [9:0] op = o_rdo[OPER_MSB:OPER_LSB];
  wire logic [9:0] lo = o_rdo[LIMIT_MSB:LIMIT_LSB];
  wire logic       gb = o_rdo[GIVEBACK_BIT];
  sequence s_build;
    i_wr && i_addr == ADDR_CTRL && i_wdata[CTRL_BUILD_BIT];
  endsequence
  sequence s_done;
    ##[3:4] (o_rdo_valid || o_rdo_error);
  endsequence
  property p_lat; s_build |-> s_done; endproperty
  property p_rsv; o_rdo_valid |-> !o_rdo[31] && o_rdo[23:20] == 4'h0; endproperty
  property p_pos; o_rdo_valid |-> o_rdo[POS_MSB:POS_LSB] != POS_RESERVED; endproperty
  property p_max; o_rdo_valid && !gb |-> op <= lo; endproperty
  property p_min; o_rdo_valid && gb |-> op >= lo; endproperty
  property p_usb; o_rdo_valid && $changed(o_rdo) |-> o_rdo[USB_COMM_BIT] == $past(i_usb_data_capable); endproperty
  property p_clr; i_caps_received |=> !o_rdo_valid; endproperty
  property p_err; o_rdo_error |-> !o_rdo_valid; endproperty
  a_lat: assert property (p_lat) else $error("build gave no result");
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  a_pos: assert property (p_pos) else $error("zero position sent");
  a_max: assert property (p_max) else $error("operating above maximum");
  a_min: assert property (p_min) else $error("operating below minimum");
  a_usb: assert property (p_usb) else $error("usb flag wrong");
  a_clr: assert property (p_clr) else $error("valid kept after new offer");
  a_err: assert property (p_err) else $error("valid with bad position");
endmodule
bind power_request_object_builder power_request_object_builder_chk u_chk (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_usb_data_capable(i_usb_data_capable),
  .i_caps_received(i_caps_received), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_rdo(o_rdo), .o_rdo_valid(o_rdo_valid), .o_rdo_error(o_rdo_error));
`default_nettype wire

/* verif/src_policy_model.sv */
`timescale 1ns/1ps
`default_nettype none
module src_policy_model
  import rdo_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic [31:0] i_rdo,
  input  wire logic        i_rdo_valid,
  input  wire logic        i_lent,
  output logic [9:0]       o_reserve,
  output logic             o_wait,
  output logic             o_reoffer
);
  wire logic [9:0] op = i_rdo[OPER_MSB:OPER_LSB];
  wire logic [9:0] lo = i_rdo[LIMIT_MSB:LIMIT_LSB];
  wire logic       gb = i_rdo[GIVEBACK_BIT];
  always_ff @(posedge i_mclk or posedge i_reset)
    if (i_reset)
    begin
      o_reserve <= 10'h0;
      o_wait    <= 1'b0;
      o_reoffer <= 1'b0;
    end
    else if (i_rdo_valid)
    begin
      o_reserve <= gb ? 10'h0 : lo - op;
      o_wait    <= i_lent && !gb && op == lo;
      o_reoffer <= i_rdo[NO_SUSPEND_BIT];
    end
endmodule
`default_nettype wire

/* verif/power_request_object_builder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module power_request_object_builder_tb;
  import rdo_pkg::*;
  logic        i_mclk = 0;
  logic        i_reset = 1;
  logic        usb = 1;
  logic        caps = 0;
  logic        wr = 0;
  logic        rd = 0;
  logic        lent = 0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  wire logic [31:0] rdata;
  wire logic [31:0] rdo;
  wire logic        valid;
  wire logic        error;
  wire logic        wt;
  wire logic        reof;
  wire logic [9:0]  rsv;
  int               err_count = 0;
  int               cmp_count = 0;
  always #4 i_mclk = ~i_mclk;
  power_request_object_builder DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_usb_data_capable(usb),
    .i_caps_received(caps), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_rdo(rdo), .o_rdo_valid(valid), .o_rdo_error(error));
  src_policy_model u_src (.i_mclk(i_mclk), .i_reset(i_reset), .i_rdo(rdo), .i_rdo_valid(valid),
    .i_lent(lent), .o_reserve(rsv), .o_wait(wt), .o_reoffer(reof));
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrt(logic [3:0] a, logic [31:0] d);
    @(posedge i_mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_mclk);
    wr    <= 1'b0;
  endtask
  task automatic rdc(string n, logic [3:0] a, logic [31:0] e);
    @(posedge i_mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_mclk);
    rd   <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic bld(logic [3:0] a, logic [31:0] d);
    wrt(a, d);
    repeat (3) @(posedge i_mclk);
    #1;
  endtask
  function automatic logic [31:0] mk(logic [2:0] p, logic g, logic m, logic u, logic s,
                                     logic [9:0] o, logic [9:0] l);
    return {1'b0, p, g, m, u, s, 4'h0, o, l};
  endfunction
  function automatic logic [31:0] ctl(logic [2:0] p, logic g, logic s);
    return {23'h0, 1'b1, 1'b0, s, 1'b0, g, 1'b0, p};
  endfunction
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_count++;
    test_done;
  end
  initial
  begin
    repeat (16) @(posedge i_mclk);
    i_reset <= 1'b0;
    #1 chk("rdo", 32'h0, rdo);
    chk("valid", 32'h0, {31'h0, valid});
    // Entry 1 fixed 150, entry 2 battery 40
    wrt(ADDR_CAPS, 32'h96);
    wrt(ADDR_CAPS + 4'h1, 32'h4000_0028);
    bld(ADDR_OPER, 32'h32);
    bld(ADDR_MAXV, 32'h64);
    bld(ADDR_MINV, 32'h14);
    bld(ADDR_CTRL, ctl(3'h1, 1'b0, 1'b0));
    chk("rdo", mk(3'h1, 0, 0, 1, 0, 10'h32, 10'h64), rdo);
    @(posedge i_mclk);
    #1 chk("reserve", 32'h32, {22'h0, rsv});
    rdc("status", ADDR_STATUS, 32'h21);
    rdc("rdo reg", ADDR_RDO, mk(3'h1, 0, 0, 1, 0, 10'h32, 10'h64));
    rdc("unmapped", 4'hf, 32'h0);
    usb <= 1'b0;
    bld(ADDR_CTRL, ctl(3'h2, 1'b1, 1'b1));
    chk("rdo", mk(3'h2, 1, 1, 0, 1, 10'h28, 10'h14), rdo);
    @(posedge i_mclk);
    #1 chk("reoffer", 32'h1, {31'h0, reof});
    usb <= 1'b1;
    bld(ADDR_MAXV, 32'hc8);
    bld(ADDR_CTRL, ctl(3'h1, 1'b0, 1'b0));
    chk("rdo", mk(3'h1, 0, 1, 1, 0, 10'h32, 10'hc8), rdo);
    bld(ADDR_OPER, 32'h1e);
    bld(ADDR_MAXV, 32'h28);
    bld(ADDR_CTRL, ctl(3'h2, 1'b0, 1'b0));
    chk("rdo", mk(3'h2, 0, 0, 1, 0, 10'h1e, 10'h28), rdo);
    lent <= 1'b1;
    bld(ADDR_OPER, 32'h28);
    chk("rdo", mk(3'h2, 0, 0, 1, 0, 10'h28, 10'h28), rdo);
    @(posedge i_mclk);
    #1 chk("wait", 32'h1, {31'h0, wt});
    @(posedge i_mclk);
    caps <= 1'b1;
    @(posedge i_mclk);
    caps <= 1'b0;
    @(posedge i_mclk);
    #1 chk("valid", 32'h0, {31'h0, valid});
    bld(ADDR_CTRL, ctl(3'h1, 1'b0, 1'b0));
    chk("error", 32'h1, {31'h0, error});
    wrt(ADDR_CAPS, 32'h96);
    bld(ADDR_CTRL, ctl(3'h0, 1'b0, 1'b0));
    chk("error", 32'h1, {31'h0, error});
    bld(ADDR_CTRL, ctl(3'h2, 1'b0, 1'b0));
    chk("error", 32'h1, {31'h0, error});
    bld(ADDR_CTRL, ctl(3'h1, 1'b0, 1'b1));
    chk("rdo", mk(3'h1, 0, 0, 1, 1, 10'h28, 10'h28), rdo);
    test_done;
  end
endmodule
`default_nettype wire
